// [design/lsdu_pkg.sv]
// package: register map, field positions and carriers for the low-side driver unit
package lsdu_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [3:0] IDX_DRIVER_DATA   = 4'h0;
  localparam logic [3:0] IDX_DRIVER_CONFIG = 4'h1;
  localparam logic [3:0] IDX_OL_STATUS     = 4'h5;
  localparam logic [3:0] IDX_OC_IRQ_EN     = 4'h6;
  localparam logic [3:0] IDX_OC_FLAGS      = 4'h7;
  localparam logic [3:0] IDX_EVT_STATUS    = 4'h8;
  localparam logic [3:0] IDX_EVT_ENABLE    = 4'h9;
  localparam logic [3:0] IDX_EVT_CLEAR     = 4'ha;

  // field positions
  localparam int CFG_DRV_EN_LSB  = 0;
  localparam int CFG_OL_EN_LSB   = 2;
  localparam int IRQ_EN_BIT      = 7;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_PAIR = 2'h0;

  // timing, clock period exposed for reference
  localparam int CLK_PERIOD_PS = 4000;

  // event bits of the summary status register
  localparam int EVT_OC0 = 0;
  localparam int EVT_OC1 = 1;
  localparam int EVT_OL0 = 2;
  localparam int EVT_OL1 = 3;
  localparam int EVT_W   = 4;

  // per-driver feedback from the analog stage
  typedef struct packed {
    logic [1:0] open_load_cmp;  // current below threshold
    logic [1:0] overcurrent;    // current above limit
  } lsdu_analog_s;

  // per-driver commands to the analog stage
  typedef struct packed {
    logic [1:0] driver_on;
    logic [1:0] driver_bias;
    logic [1:0] ol_detect_on;
  } lsdu_stage_s;

endpackage

// [design/lsdu_top.sv]
// file: control and protection logic for two low-side relay drivers
//
// The register offsets and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/10ps

// What this block does
// - enable bits 1-0 bias each driver
// - config bits 3-2 enable open-load detection
// - detection active: enabled, biased, source off
// - status bits report open-load comparator result
// - status updates only while detection conditions hold
// - bit 7 gates over-current interrupt request
// - flags readable; write one clears
// - flag sets on over-current report
// - set flag forces driver off
// - cleared flag returns control to source
// - flag sticky until software clears
// - selected data bit switches driver
// - over-current detected only while enabled
// - stop keeps flags; irq only in run
module lsdu_top
(
  // clock and reset
  input  wire  logic                  clk_sys,
  input  wire  logic                  reset,
  // wishbone classic slave
  input  wire  logic                  wb_cyc_i,
  input  wire  logic                  wb_stb_i,
  input  wire  logic                  wb_we_i,
  input  wire  logic [5:0]            wb_adr_i,
  input  wire  logic [3:0]            wb_sel_i,
  input  wire  logic [31:0]           wb_dat_i,
  output logic       [31:0]           wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        wb_err_o,
  // routing unit: alternate source per driver
  input  wire  logic [1:0]            route_select,
  input  wire  logic [1:0]            route_level,
  // mcu mode
  input  wire  logic                  stop_mode,
  // analog stage, asynchronous comparator outputs
  input  wire  lsdu_pkg::lsdu_analog_s analog_in,
  output lsdu_pkg::lsdu_stage_s       stage_out,
  // interrupt
  output logic                        irq
);

  // ---- pin synchronisers: two flops before any use
  lsdu_pkg::lsdu_analog_s sync1_q;
  lsdu_pkg::lsdu_analog_s sync2_q;

  // comparator outputs come from the analog domain
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= analog_in;
      sync2_q <= sync1_q;
    end
  end

  // ---- register state
  logic [1:0] data_q;
  logic [1:0] drv_en_q;
  logic [1:0] ol_en_q;
  logic [1:0] ol_stat_q;
  logic [1:0] ol_stat_d;
  logic       oc_ie_q;
  logic [1:0] oc_flag_q;
  logic [1:0] oc_flag_d;
  logic [lsdu_pkg::EVT_W-1:0] evt_q;
  logic [lsdu_pkg::EVT_W-1:0] evt_d;
  logic [lsdu_pkg::EVT_W-1:0] evt_en_q;
  logic       ack_q;
  logic       err_q;
  logic [31:0] rdata_q;

  // ---- bus decode
  wire        req     = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
  wire [3:0]  idx     = wb_adr_i[5:2];
  wire        wr      = req && wb_we_i && wb_sel_i[0];
  wire [7:0]  wbyte   = wb_dat_i[7:0];
  wire        hit_dat = (idx == lsdu_pkg::IDX_DRIVER_DATA);
  wire        hit_cfg = (idx == lsdu_pkg::IDX_DRIVER_CONFIG);
  wire        hit_ols = (idx == lsdu_pkg::IDX_OL_STATUS);
  wire        hit_ie  = (idx == lsdu_pkg::IDX_OC_IRQ_EN);
  wire        hit_ocf = (idx == lsdu_pkg::IDX_OC_FLAGS);
  wire        hit_evs = (idx == lsdu_pkg::IDX_EVT_STATUS);
  wire        hit_eve = (idx == lsdu_pkg::IDX_EVT_ENABLE);
  wire        hit_evc = (idx == lsdu_pkg::IDX_EVT_CLEAR);
  wire        mapped  = hit_dat | hit_cfg | hit_ols | hit_ie | hit_ocf
                      | hit_evs | hit_eve | hit_evc;

  // ---- driver control path
  wire [1:0] src_level = (route_select & route_level) | (~route_select & data_q);
  wire [1:0] drive_on  = drv_en_q & src_level & ~oc_flag_q;
  wire [1:0] ol_active = ol_en_q & drv_en_q & ~src_level;
  wire [1:0] oc_event  = sync2_q.overcurrent & drv_en_q;
  wire [1:0] oc_clear  = (wr && hit_ocf) ? wbyte[1:0] : 2'h0;

  // read-back of the data register shows the selected source when biased
  wire [1:0] data_view = (drv_en_q & src_level) | (~drv_en_q & data_q);

  // ---- next-state for flags; set listed last so it wins over clear
  always_comb
  begin
    oc_flag_d = (oc_flag_q & ~oc_clear) | oc_event;
    for (int i = 0; i < 2; i++)
    begin
      ol_stat_d[i] = ol_active[i] ? sync2_q.open_load_cmp[i] : ol_stat_q[i];
    end
  end

  // summary events: over-current and open-load rising report
  wire [lsdu_pkg::EVT_W-1:0] evt_set = {ol_stat_d & ~ol_stat_q, oc_event & ~oc_flag_q};
  wire [lsdu_pkg::EVT_W-1:0] evt_clr = (wr && hit_evc) ? wbyte[lsdu_pkg::EVT_W-1:0]
                                                       : '0;
  assign evt_d = (evt_q & ~evt_clr) | evt_set;

  // ---- read mux, unused bits zero
  wire [7:0] rd_byte =
      hit_dat ? {6'h00, data_view} :
      hit_cfg ? {4'h0, ol_en_q, drv_en_q} :
      hit_ols ? {6'h00, ol_stat_q} :
      hit_ie  ? {oc_ie_q, 7'h00} :
      hit_ocf ? {6'h00, oc_flag_q} :
      hit_evs ? {4'h0, evt_q} :
      hit_eve ? {4'h0, evt_en_q} : 8'h00;

  // control registers; stop clears only the data bits
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      data_q   <= lsdu_pkg::RST_PAIR;
      drv_en_q <= lsdu_pkg::RST_PAIR;
      ol_en_q  <= lsdu_pkg::RST_PAIR;
      oc_ie_q  <= 1'b0;
      evt_en_q <= '0;
    end
    else
    begin
      if (stop_mode)
        data_q <= lsdu_pkg::RST_PAIR;
      else if (wr && hit_dat)
        data_q <= wbyte[1:0];
      if (wr && hit_cfg)
      begin
        drv_en_q <= wbyte[lsdu_pkg::CFG_DRV_EN_LSB +: 2];
        ol_en_q  <= wbyte[lsdu_pkg::CFG_OL_EN_LSB +: 2];
      end
      if (wr && hit_ie)
        oc_ie_q <= wbyte[lsdu_pkg::IRQ_EN_BIT];
      if (wr && hit_eve)
        evt_en_q <= wbyte[lsdu_pkg::EVT_W-1:0];
    end
  end

  // status and flags; stop mode leaves the flags alone
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      oc_flag_q <= lsdu_pkg::RST_PAIR;
      ol_stat_q <= lsdu_pkg::RST_PAIR;
      evt_q     <= '0;
    end
    else
    begin
      oc_flag_q <= oc_flag_d;
      ol_stat_q <= ol_stat_d;
      evt_q     <= evt_d;
    end
  end

  // bus answer: one wait-free cycle, ack or err
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q   <= req && mapped;
      err_q   <= req && !mapped;
      rdata_q <= (req && mapped && !wb_we_i) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = rdata_q;

  // interrupt: over-current request gated by bit 7, plus summary events, run mode only
  wire oc_req  = oc_ie_q && (oc_flag_q != 2'h0);
  wire evt_req = (evt_q & evt_en_q) != '0;
  assign irq = !stop_mode && (oc_req || evt_req);

  // stage commands
  assign stage_out.driver_on    = drive_on;
  assign stage_out.driver_bias  = drv_en_q;
  assign stage_out.ol_detect_on = ol_active;

endmodule

// [testbench/lsdu_stage_model.sv]
// model: analog output stage of two low-side drivers
`timescale 1ns/10ps
module lsdu_stage_model
(
  // commands and bench-set load faults
  input  wire lsdu_pkg::lsdu_stage_s  stage,
  input  wire logic [1:0]             oc_load,
  input  wire logic [1:0]             ol_load,
  // comparator results
  output lsdu_pkg::lsdu_analog_s      analog
);
  // current flows only in a biased, conducting stage
  assign analog.overcurrent = oc_load & stage.driver_on & stage.driver_bias;
  // idle comparator shows the inverse, never a stale match
  // chosen per driver, so one detecting stage does not unmask the other
  assign analog.open_load_cmp = (stage.ol_detect_on & ol_load)
                              | (~stage.ol_detect_on & ~ol_load);
endmodule

// [testbench/lsdu_chk.sv]
// checker: port assertions for the low-side driver unit
`timescale 1ns/10ps
module lsdu_chk
(
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset,
  // bus
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic                   wb_we_i,
  input wire logic [5:0]             wb_adr_i,
  input wire logic [3:0]             wb_sel_i,
  input wire logic [31:0]            wb_dat_i,
  input wire logic [31:0]            wb_dat_o,
  input wire logic                   wb_ack_o,
  // mode, stage, interrupt
  input wire logic                   stop_mode,
  input wire lsdu_pkg::lsdu_analog_s analog_in,
  input wire lsdu_pkg::lsdu_stage_s  stage_out,
  input wire logic                   irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // request decodes; the ack cycle still holds the request
  logic cfg_wr;
  logic flag_rd;
  assign cfg_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & (wb_adr_i[5:2] == 4'h1);
  assign flag_rd = wb_cyc_i & wb_stb_i & !wb_we_i & (wb_adr_i[5:2] == 4'h7);
  AST_BIAS: assert property (wb_ack_o && $past(cfg_wr) |->
    stage_out.driver_bias == $past(wb_dat_i[1:0])) else $error("bias differs from write");
  AST_OFF: assert property (!(|(stage_out.driver_on & ~stage_out.driver_bias)))
    else $error("unbiased driver on");
  AST_OLDET: assert property (!(|(stage_out.ol_detect_on &
    (stage_out.driver_on | ~stage_out.driver_bias)))) else $error("detection misplaced");
  AST_OC0: assert property (analog_in.overcurrent[0] && stage_out.driver_bias[0]
    |-> ##[0:4] !stage_out.driver_on[0]) else $error("driver 0 not forced off");
  AST_OC1: assert property (analog_in.overcurrent[1] && stage_out.driver_bias[1]
    |-> ##[0:4] !stage_out.driver_on[1]) else $error("driver 1 not forced off");
  AST_STOP: assert property (irq |-> !stop_mode) else $error("irq in stop");
  AST_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  AST_FLAGS: assert property (wb_ack_o && $past(flag_rd) |-> wb_dat_o[7:2] == 6'h0)
    else $error("unused flag bits set");
endmodule
bind lsdu_top lsdu_chk i_lsdu_chk (.clk_sys, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .stop_mode, .analog_in,
  .stage_out, .irq);

// [testbench/lsdu_top_tb.sv]
// bench: register-level tests of the low-side driver unit
`timescale 1ns/10ps
module lsdu_top_tb;
  logic                   clk_sys = 1'b0, reset = 1'b1, cyc = 1'b0, we = 1'b0, stop = 1'b0;
  logic                   ack, err, irq, berr;
  logic [5:0]             adr = 6'h00;
  logic [7:0]             dat = 8'h00;
  logic [1:0]             rsel = 2'h0, oc_ld = 2'h0, ol_ld = 2'h0;
  logic [31:0]            rdat;
  int                     fails = 0, num_checks = 0;
  lsdu_pkg::lsdu_analog_s ana;
  lsdu_pkg::lsdu_stage_s  stg;
  localparam logic [5:0]  RA [4] = '{6'h04, 6'h14, 6'h18, 6'h1c};

  // 4 ns clock
  always #2 clk_sys = ~clk_sys;

  // strobe rides with cycle; routed level follows its select
  lsdu_top i_lsdu_top (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i({24'h0, dat}), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .route_select(rsel), .route_level(rsel),
    .stop_mode(stop), .analog_in(ana), .stage_out(stg), .irq(irq));
  lsdu_stage_model i_lsdu_stage_model (.stage(stg), .oc_load(oc_ld), .ol_load(ol_ld),
    .analog(ana));

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one classic cycle, held until ack or err is seen
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (!(ack || err) && n < 20);
    // a missing answer is a mismatch, not a silent pass
    if (!(ack || err))
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
    end
    berr = err;
    cyc <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(rdat[7:0], e);
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard, far beyond the hundred or so cycles needed
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    end_of_test();
  end

  // tests
  initial
  begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(RA[i], 8'h00);
    rd(6'h0c, 8'h00);
    chk(8'(berr), 8'h01);
    $display("reset and map test done");
    ol_ld <= 2'h1;
    bus(6'h04, 1'b1, 8'h0f);
    rd(6'h04, 8'h0f);
    chk(8'(stg.driver_bias), 8'h03);
    repeat (8) @(posedge clk_sys);
    rd(6'h14, 8'h01);
    bus(6'h00, 1'b1, 8'h01);
    chk(8'(stg.driver_on), 8'h01);
    ol_ld <= 2'h2;
    repeat (8) @(posedge clk_sys);
    rd(6'h14, 8'h03);
    bus(6'h18, 1'b1, 8'h80);
    oc_ld <= 2'h1;
    repeat (6) @(posedge clk_sys);
    chk(8'(stg.driver_on), 8'h00);
    chk(8'(irq), 8'h01);
    oc_ld <= 2'h0;
    rd(6'h1c, 8'h01);
    bus(6'h1c, 1'b1, 8'h00);
    rd(6'h1c, 8'h01);
    stop <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(8'(irq), 8'h00);
    stop <= 1'b0;
    rd(6'h1c, 8'h01);
    rd(6'h20, 8'h0d);
    bus(6'h18, 1'b1, 8'h00);
    chk(8'(irq), 8'h00);
    bus(6'h24, 1'b1, 8'h01);
    chk(8'(irq), 8'h01);
    bus(6'h28, 1'b1, 8'h0f);
    chk(8'(irq), 8'h00);
    rsel <= 2'h1;
    bus(6'h1c, 1'b1, 8'h01);
    rd(6'h1c, 8'h00);
    chk(8'(stg.driver_on), 8'h01);
    $display("drive and protect test done");
    end_of_test();
  end
endmodule
